/* dcs_cfg.svh */
// timing constants for the daisy chain command timing ends
// Operation
// - stand-alone start equals command end
// - chain devices below the top start before command finishes
// - broadcast completes when top device receives
// - start times grow per stack position
// - completion time grows with stack size
// - host idles nine chain clocks after response
// - wait measured from last chain edge
// - host waits 18/36/72/144 us per rate
// - host budgets spi frame plus chain bits and tail clocks
// - budgets assume chain clock ten percent slow
// - master forwards after first byte received
// - each higher device adds one chain clock
`ifndef DCS_CFG_SVH
`define DCS_CFG_SVH
`define DCS_CLK_PERIOD_NS 4
`define DCS_LINK_PERIOD_NS 80
`define DCS_SPI_PERIOD_NS 500
`define DCS_CMD_BITS 24
`define DCS_BYTE_BITS 8
`define DCS_MAX_DEV 14
`define DCS_CHAIN_NS_500 2000
`define DCS_CHAIN_NS_250 4000
`define DCS_CHAIN_NS_125 8000
`define DCS_CHAIN_NS_62 16000
`define DCS_WAIT_US_500 18
`define DCS_WAIT_US_250 36
`define DCS_WAIT_US_125 72
`define DCS_WAIT_US_62 144
`define DCS_SLOW_NUM 10
`define DCS_SLOW_DEN 9
`define DCS_TURN_CLOCKS 8
`endif

/* dcs_dev_end.sv */
// master device end: spi receive, chain forward, per-device start pulses
`timescale 1ns/10ps
`default_nettype none
`include "dcs_cfg.svh"
module dcs_dev_end import dcs_pkg::*; #(
	parameter int MAX_DEV = `DCS_MAX_DEV
) (
	input wire logic linkClk,
	input wire logic rst,
	dcs_link_if.dev link,
	input wire logic [3:0] stackSize,
	input wire dcs_rate_t rateSel,
	input wire logic respActive,
	output logic chainClk,
	output logic chainData,
	output logic [MAX_DEV-1:0] devStart,
	output logic cmdDone,
	output logic [`DCS_CMD_BITS-1:0] cmdWord
);
	localparam int BW = $clog2(`DCS_CMD_BITS + 1);

	function automatic logic [11:0] chainCyc(input dcs_rate_t r);
		unique case (r)
			DCS_RATE_500: chainCyc = 12'(`DCS_CHAIN_NS_500 / `DCS_LINK_PERIOD_NS);
			DCS_RATE_250: chainCyc = 12'(`DCS_CHAIN_NS_250 / `DCS_LINK_PERIOD_NS);
			DCS_RATE_125: chainCyc = 12'(`DCS_CHAIN_NS_125 / `DCS_LINK_PERIOD_NS);
			DCS_RATE_62: chainCyc = 12'(`DCS_CHAIN_NS_62 / `DCS_LINK_PERIOD_NS);
		endcase
	endfunction : chainCyc

	// sync bits: 0 sclk, 1 csN, 2 mosi
	logic [2:0] sync1_r, sync2_r;
	logic sclkPrev_r, sclkPrev_nxt;
	dcs_dstate_t state_r, state_nxt;
	logic [BW-1:0] bitCnt_r, bitCnt_nxt;
	logic [BW-1:0] chIdx_r, chIdx_nxt;
	logic [3:0] extra_r, extra_nxt;
	logic [11:0] div_r, div_nxt;
	logic [`DCS_CMD_BITS-1:0] cmd_r, cmd_nxt;
	logic chainClk_r, chainClk_nxt;
	logic chainData_r, chainData_nxt;
	logic [MAX_DEV-1:0] start_r, start_nxt;
	logic done_r, done_nxt;
	logic busy_r, busy_nxt;
	logic sclkRise, sclkFall, csActive, tick, cmdEnd;
	logic [11:0] period;

	always_comb begin
		sclkRise = sync2_r[0] & ~sclkPrev_r;
		sclkFall = ~sync2_r[0] & sclkPrev_r;
		csActive = ~sync2_r[1];
		period = chainCyc(rateSel);
		tick = (div_r == period - 12'h001);
		cmdEnd = sclkFall && csActive && (bitCnt_r == BW'(`DCS_CMD_BITS));
		sclkPrev_nxt = sync2_r[0];
		bitCnt_nxt = bitCnt_r;
		cmd_nxt = cmd_r;
		state_nxt = state_r;
		chIdx_nxt = chIdx_r;
		extra_nxt = extra_r;
		div_nxt = div_r;
		chainClk_nxt = chainClk_r;
		chainData_nxt = chainData_r;
		start_nxt = '0;
		done_nxt = 1'b0;
		busy_nxt = respActive;
		if (!csActive && state_r == DCS_D_IDLE) begin
			bitCnt_nxt = '0;
		end else if (csActive && sclkRise && bitCnt_r < BW'(`DCS_CMD_BITS)) begin
			cmd_nxt[`DCS_CMD_BITS-1-int'(bitCnt_r)] = sync2_r[2];
			bitCnt_nxt = bitCnt_r + BW'(1);
		end
		if (cmdEnd) begin
			// master starts on the last spi falling edge
			start_nxt[0] = 1'b1;
			if (stackSize <= 4'h1) begin
				done_nxt = 1'b1;
			end
		end
		unique case (state_r)
			DCS_D_IDLE: begin
				chIdx_nxt = '0;
				extra_nxt = '0;
				div_nxt = '0;
				chainClk_nxt = 1'b0;
				if (stackSize > 4'h1 && bitCnt_r >= BW'(`DCS_BYTE_BITS)) begin
					state_nxt = DCS_D_FWD;
				end
			end
			DCS_D_FWD, DCS_D_TAIL: begin
				div_nxt = tick ? 12'h000 : div_r + 12'h001;
				chainClk_nxt = div_r < (period >> 1);
				if (div_r == 12'h000 && state_r == DCS_D_FWD) begin
					// spi outruns the chain, so the bit is already here
					chainData_nxt = cmd_r[`DCS_CMD_BITS-1-int'(chIdx_r)];
				end
				if (tick && state_r == DCS_D_FWD) begin
					chIdx_nxt = chIdx_r + BW'(1);
					if (chIdx_r == BW'(`DCS_CMD_BITS - 1)) begin
						state_nxt = DCS_D_TAIL;
					end
				end else if (tick) begin
					// one extra chain clock per higher device
					start_nxt[int'(extra_r) + 1] = 1'b1;
					extra_nxt = extra_r + 4'h1;
					if (extra_r + 4'h2 >= stackSize) begin
						done_nxt = 1'b1;
						state_nxt = DCS_D_IDLE;
						bitCnt_nxt = '0;
						chainData_nxt = 1'b0;
					end
				end
			end
			default: state_nxt = DCS_D_IDLE;
		endcase
	end

	always_ff @(posedge linkClk or posedge rst) begin
		if (rst) begin
			// sclk idles low, csN high: no false edge after reset
			sync1_r <= 3'h2;
			sync2_r <= 3'h2;
			sclkPrev_r <= 1'b0;
			state_r <= DCS_D_IDLE;
			bitCnt_r <= '0;
			chIdx_r <= '0;
			extra_r <= 4'h0;
			div_r <= 12'h000;
			cmd_r <= '0;
			chainClk_r <= 1'b0;
			chainData_r <= 1'b0;
			start_r <= '0;
			done_r <= 1'b0;
			busy_r <= 1'b0;
		end else begin
			sync1_r <= {link.mosi, link.csN, link.sclk};
			sync2_r <= sync1_r;
			sclkPrev_r <= sclkPrev_nxt;
			state_r <= state_nxt;
			bitCnt_r <= bitCnt_nxt;
			chIdx_r <= chIdx_nxt;
			extra_r <= extra_nxt;
			div_r <= div_nxt;
			cmd_r <= cmd_nxt;
			chainClk_r <= chainClk_nxt;
			chainData_r <= chainData_nxt;
			start_r <= start_nxt;
			done_r <= done_nxt;
			busy_r <= busy_nxt;
		end
	end

	assign link.chainBusy = busy_r;
	assign chainClk = chainClk_r;
	assign chainData = chainData_r;
	assign devStart = start_r;
	assign cmdDone = done_r;
	assign cmdWord = cmd_r;
endmodule : dcs_dev_end
`default_nettype wire

/* dcs_host_end.sv */
// host end: spi command sender with inter-command wait and budget
`timescale 1ns/10ps
`default_nettype none
`include "dcs_cfg.svh"
module dcs_host_end import dcs_pkg::*; #(
	parameter int WAIT_500_CYC = `DCS_WAIT_US_500 * 1000 / `DCS_CLK_PERIOD_NS,
	parameter int WAIT_250_CYC = `DCS_WAIT_US_250 * 1000 / `DCS_CLK_PERIOD_NS,
	parameter int WAIT_125_CYC = `DCS_WAIT_US_125 * 1000 / `DCS_CLK_PERIOD_NS,
	parameter int WAIT_62_CYC = `DCS_WAIT_US_62 * 1000 / `DCS_CLK_PERIOD_NS
) (
	input wire logic clock,
	input wire logic rst,
	dcs_link_if.host link,
	input wire logic [3:0] stackSize,
	input wire dcs_rate_t rateSel,
	input wire logic cmdValid,
	input wire logic [`DCS_CMD_BITS-1:0] cmdData,
	output logic cmdReady,
	output logic [31:0] budgetNs
);
	localparam int SPI_CYC = `DCS_SPI_PERIOD_NS / `DCS_CLK_PERIOD_NS;
	localparam int BW = $clog2(`DCS_CMD_BITS + 1);

	function automatic logic [15:0] waitCyc(input dcs_rate_t r);
		unique case (r)
			DCS_RATE_500: waitCyc = 16'(WAIT_500_CYC);
			DCS_RATE_250: waitCyc = 16'(WAIT_250_CYC);
			DCS_RATE_125: waitCyc = 16'(WAIT_125_CYC);
			DCS_RATE_62: waitCyc = 16'(WAIT_62_CYC);
		endcase
	endfunction : waitCyc

	function automatic logic [31:0] chainNs(input dcs_rate_t r);
		unique case (r)
			DCS_RATE_500: chainNs = 32'(`DCS_CHAIN_NS_500);
			DCS_RATE_250: chainNs = 32'(`DCS_CHAIN_NS_250);
			DCS_RATE_125: chainNs = 32'(`DCS_CHAIN_NS_125);
			DCS_RATE_62: chainNs = 32'(`DCS_CHAIN_NS_62);
		endcase
	endfunction : chainNs

	// command end estimate: spi bits, then chain bits plus tail clocks
	function automatic logic [31:0] cmdBudget(input logic [3:0] n,
			input dcs_rate_t r);
		logic [31:0] spiNs;
		logic [31:0] chBits;
		spiNs = 32'(`DCS_CMD_BITS * `DCS_SPI_PERIOD_NS);
		chBits = (n > 4'h1) ? 32'(`DCS_CMD_BITS) + 32'(n) - 32'h2 : 32'h0;
		// chain taken slow; spi is crystal so nominal
		cmdBudget = spiNs + chBits * chainNs(r) * 32'(`DCS_SLOW_NUM)
			/ 32'(`DCS_SLOW_DEN);
	endfunction : cmdBudget

	logic busy1_r, busy2_r, busyPrev_r, busyPrev_nxt;
	dcs_hstate_t state_r, state_nxt;
	logic [15:0] wait_r, wait_nxt;
	logic [7:0] div_r, div_nxt;
	logic [BW-1:0] bitCnt_r, bitCnt_nxt;
	logic [`DCS_CMD_BITS-1:0] sh_r, sh_nxt;
	logic sclk_r, sclk_nxt, csN_r, csN_nxt, mosi_r, mosi_nxt;
	logic [31:0] budget_r, budget_nxt;
	logic bitEnd;

	always_comb begin
		// wait loads one cycle after busy falls, so gate on that cycle too
		cmdReady = (state_r == DCS_H_IDLE) && (wait_r == 16'h0000)
			&& !busy2_r && !busyPrev_r;
		bitEnd = (div_r == 8'(SPI_CYC - 1));
		busyPrev_nxt = busy2_r;
		state_nxt = state_r;
		wait_nxt = (wait_r != 16'h0000) ? wait_r - 16'h0001 : wait_r;
		div_nxt = div_r;
		bitCnt_nxt = bitCnt_r;
		sh_nxt = sh_r;
		sclk_nxt = sclk_r;
		csN_nxt = csN_r;
		mosi_nxt = mosi_r;
		budget_nxt = budget_r;
		if (!busy2_r && busyPrev_r) begin
			// last edge on the incoming chain port restarts the wait
			wait_nxt = waitCyc(rateSel);
		end
		unique case (state_r)
			DCS_H_IDLE: begin
				if (cmdValid && cmdReady) begin
					sh_nxt = cmdData;
					budget_nxt = cmdBudget(stackSize, rateSel);
					csN_nxt = 1'b0;
					div_nxt = 8'h00;
					bitCnt_nxt = '0;
					state_nxt = DCS_H_SHIFT;
				end
			end
			DCS_H_SHIFT: begin
				div_nxt = bitEnd ? 8'h00 : div_r + 8'h01;
				if (div_r == 8'h00) begin
					mosi_nxt = sh_r[`DCS_CMD_BITS-1];
				end
				sclk_nxt = div_r >= 8'(SPI_CYC / 2);
				if (bitEnd) begin
					sh_nxt = {sh_r[`DCS_CMD_BITS-2:0], 1'b0};
					bitCnt_nxt = bitCnt_r + BW'(1);
					if (bitCnt_r == BW'(`DCS_CMD_BITS - 1)) begin
						state_nxt = DCS_H_END;
					end
				end
			end
			DCS_H_END: begin
				// hold csN low one spi period so the last fall is seen
				sclk_nxt = 1'b0;
				div_nxt = bitEnd ? 8'h00 : div_r + 8'h01;
				if (bitEnd) begin
					csN_nxt = 1'b1;
					mosi_nxt = 1'b0;
					state_nxt = DCS_H_IDLE;
				end
			end
			default: state_nxt = DCS_H_IDLE;
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			busy1_r <= 1'b0;
			busy2_r <= 1'b0;
			busyPrev_r <= 1'b0;
			state_r <= DCS_H_IDLE;
			wait_r <= 16'h0000;
			div_r <= 8'h00;
			bitCnt_r <= '0;
			sh_r <= '0;
			sclk_r <= 1'b0;
			csN_r <= 1'b1;
			mosi_r <= 1'b0;
			budget_r <= 32'h00000000;
		end else begin
			busy1_r <= link.chainBusy;
			busy2_r <= busy1_r;
			busyPrev_r <= busyPrev_nxt;
			state_r <= state_nxt;
			wait_r <= wait_nxt;
			div_r <= div_nxt;
			bitCnt_r <= bitCnt_nxt;
			sh_r <= sh_nxt;
			sclk_r <= sclk_nxt;
			csN_r <= csN_nxt;
			mosi_r <= mosi_nxt;
			budget_r <= budget_nxt;
		end
	end

	assign link.sclk = sclk_r;
	assign link.csN = csN_r;
	assign link.mosi = mosi_r;
	assign budgetNs = budget_r;
endmodule : dcs_host_end
`default_nettype wire

/* dcs_link_checker.sv */
// checker for the host to master command link
`timescale 1ns/10ps
`default_nettype none
module dcs_link_checker #(
	parameter int MIN_WAIT = 50
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic sclk,
	input wire logic csN,
	input wire logic mosi,
	input wire logic chainBusy
);
	logic sclkQ_r;
	logic [4:0] riseCnt_r, riseCnt_nxt;
	logic [15:0] lowCnt_r, lowCnt_nxt, idleCnt_r, idleCnt_nxt;
	always_comb begin
		riseCnt_nxt = riseCnt_r;
		if (csN)
			riseCnt_nxt = 5'h00;
		else if (sclk && !sclkQ_r)
			riseCnt_nxt = riseCnt_r + 5'h01;
		lowCnt_nxt = csN ? 16'h0000 : lowCnt_r + 16'h0001;
		// saturates so a long idle never wraps into a short gap
		idleCnt_nxt = chainBusy ? 16'h0000 : idleCnt_r + {15'h0, ~&idleCnt_r};
	end
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sclkQ_r <= 1'b0;
			riseCnt_r <= 5'h00;
			lowCnt_r <= 16'h0000;
			idleCnt_r <= 16'hFFFF;
		end else begin
			sclkQ_r <= sclk;
			riseCnt_r <= riseCnt_nxt;
			lowCnt_r <= lowCnt_nxt;
			idleCnt_r <= idleCnt_nxt;
		end
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	property p_idle; csN |-> !sclk; endproperty
	a_idle: assert property (p_idle) else $error("sclk high idle");
	property p_lead; $fell(csN) |=> !sclk [*8]; endproperty
	a_lead: assert property (p_lead) else $error("short lead");
	property p_mosi; sclk && $past(sclk) |-> $stable(mosi); endproperty
	a_mosi: assert property (p_mosi) else $error("mosi moved");
	property p_bits; $rose(csN) |-> riseCnt_r == 5'h18; endproperty
	a_bits: assert property (p_bits) else $error("bit count");
	property p_frame; $rose(csN) |-> lowCnt_r inside {[16'hC2B:16'hC3F]};
	endproperty
	a_frame: assert property (p_frame) else $error("frame length");
	property p_wait; $fell(csN) |-> idleCnt_r >= MIN_WAIT; endproperty
	a_wait: assert property (p_wait) else $error("wait short");
	property p_busy; chainBusy |-> csN; endproperty
	a_busy: assert property (p_busy) else $error("frame in response");
	property p_gap; $rose(csN) |-> csN [*8]; endproperty
	a_gap: assert property (p_gap) else $error("gap short");
endmodule : dcs_link_checker
`default_nettype wire

/* dcs_link_if.sv */
// serial command link between host and master device
`timescale 1ns/10ps
`default_nettype none
interface dcs_link_if;
	logic sclk;
	logic csN;
	logic mosi;
	logic chainBusy;
	modport host (output sclk, output csN, output mosi, input chainBusy);
	modport dev (input sclk, input csN, input mosi, output chainBusy);
endinterface : dcs_link_if
`default_nettype wire

/* dcs_pkg.sv */
// types shared by both ends of the daisy chain command link
package dcs_pkg;
	typedef enum logic [1:0] {
		DCS_RATE_500,
		DCS_RATE_250,
		DCS_RATE_125,
		DCS_RATE_62
	} dcs_rate_t;
	typedef enum logic [1:0] {
		DCS_H_IDLE,
		DCS_H_SHIFT,
		DCS_H_END
	} dcs_hstate_t;
	typedef enum logic [1:0] {
		DCS_D_IDLE,
		DCS_D_FWD,
		DCS_D_TAIL
	} dcs_dstate_t;
endpackage : dcs_pkg

/* test_daisy_chain_command_timing.sv */
// bench joining host end and master device end
`timescale 1ns/10ps
`default_nettype none
module test_daisy_chain_command_timing import dcs_pkg::*;;
	localparam int W[4] = '{50, 100, 200, 400};
	localparam int P[4] = '{25, 50, 100, 200};
	localparam int NS[4] = '{2000, 4000, 8000, 16000};
	logic clock = 1'b0;
	logic linkClk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] stackSize = 4'h1;
	dcs_rate_t rateSel = DCS_RATE_500;
	logic cmdValid = 1'b0;
	logic [23:0] cmdData = 24'h000000;
	logic respActive = 1'b0;
	logic cmdReady, chainClk, chainData, cmdDone, clkQ;
	logic [31:0] budgetNs;
	logic [13:0] devStart;
	logic [23:0] cmdWord;
	logic [23:0] chSh;
	int n_fail = 0, n_checks = 0, cyc = 0, lc = 0, tDone = 0, nDone, nClk;
	int tSt[14];
	int nPul[14];
	dcs_link_if link ();
	dcs_host_end #(.WAIT_500_CYC(50), .WAIT_250_CYC(100),
		.WAIT_125_CYC(200), .WAIT_62_CYC(400)) dcs_host_end_inst (
		.clock(clock), .rst(rst), .link(link), .stackSize(stackSize),
		.rateSel(rateSel), .cmdValid(cmdValid), .cmdData(cmdData),
		.cmdReady(cmdReady), .budgetNs(budgetNs));
	dcs_dev_end dcs_dev_end_inst (.linkClk(linkClk),
		.rst(rst), .link(link), .stackSize(stackSize), .rateSel(rateSel),
		.respActive(respActive), .chainClk(chainClk), .chainData(chainData),
		.devStart(devStart), .cmdDone(cmdDone), .cmdWord(cmdWord));
	dcs_link_checker #(.MIN_WAIT(50)) dcs_link_checker_inst (.clock(clock),
		.rst(rst), .sclk(link.sclk), .csN(link.csN), .mosi(link.mosi),
		.chainBusy(link.chainBusy));
	initial forever #2 clock = ~clock;
	// offset keeps the two clocks out of step
	initial begin
		#7;
		forever #40 linkClk = ~linkClk;
	end
	always @(posedge linkClk) begin
		lc++;
		if (chainClk === 1'b1 && clkQ === 1'b0) begin
			if (nClk < 24)
				chSh = {chSh[22:0], chainData};
			nClk++;
		end
		clkQ = chainClk;
		for (int k = 0; k < 14; k++)
			if (devStart[k] === 1'b1) begin
				nPul[k]++;
				tSt[k] = lc;
			end
		if (cmdDone === 1'b1) begin
			nDone++;
			tDone = lc;
		end
	end
	task automatic chk(input string nm, input logic [31:0] e, g);
		n_checks++;
		if (g !== e) begin
			n_fail++;
			$display("BAD %s exp %0d got %0d", nm, e, g);
		end
	endtask : chk
	task automatic rng(input string nm, input int lo, hi, input logic [31:0] g);
		n_checks++;
		if (((g >= lo) && (g <= hi)) !== 1'b1) begin
			n_fail++;
			$display("BAD %s exp %0d..%0d got %0d", nm, lo, hi, g);
		end
	endtask : rng
	task automatic send(input logic [23:0] d);
		while (cmdReady !== 1'b1)
			@(negedge clock);
		@(posedge clock);
		cmdValid <= 1'b1;
		cmdData <= d;
		@(posedge clock);
		cmdValid <= 1'b0;
	endtask : send
	task automatic run(input int n, input dcs_rate_t r, input logic [23:0] d);
		int t;
		@(posedge clock);
		stackSize <= n[3:0];
		rateSel <= r;
		repeat (4) @(posedge clock);
		foreach (nPul[k])
			nPul[k] = 0;
		nDone = 0;
		nClk = 0;
		chSh = '0;
		send(d);
		while (nDone == 0)
			@(negedge clock);
		repeat (30) @(negedge clock);
		chk("budget", n > 1 ? 12000 + (22 + n) * NS[r] * 10 / 9 : 12000,
			budgetNs);
		chk("word", {8'h00, d}, {8'h00, cmdWord});
		for (int k = 0; k < 14; k++)
			chk("pulses", k < n, nPul[k]);
		chk("chain clocks", n > 1 ? 23 + n : 0, nClk);
		if (n == 1)
			chk("solo done", tSt[0], tDone);
		else begin
			chk("top done", tSt[n-1], tDone);
			rng("lead", 25 * P[r] - 110, 25 * P[r] - 85, tSt[1] - tSt[0]);
			for (int k = 1; k < n - 1; k++)
				chk("step", P[r], tSt[k+1] - tSt[k]);
			if (n > 2)
				rng("early", 1, 99999, tDone - tSt[1]);
			chk("chain data", {8'h00, d}, {8'h00, chSh});
		end
		// a response may only come once the frame has closed
		while (link.csN !== 1'b1)
			@(negedge clock);
		@(posedge linkClk);
		respActive <= 1'b1;
		repeat (4) @(posedge linkClk);
		respActive <= 1'b0;
		t = 0;
		while (cmdReady !== 1'b1) begin
			@(negedge clock);
			t++;
		end
		rng("wait", W[r] + 16, W[r] + 30, t);
	endtask : run
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : final_report
	always @(posedge clock) begin
		cyc++;
		if (cyc == 80000) begin
			n_fail++;
			final_report();
		end
	end
	initial begin
		// held longer than asked so the link clock sees two edges
		repeat (40) @(posedge clock);
		rst <= 1'b0;
		run(1, DCS_RATE_62, 24'hA5C3F0);
		run(1, DCS_RATE_125, 24'h0F1E2D);
		run(14, DCS_RATE_500, 24'hFFFF01);
		run(2, DCS_RATE_250, 24'h800001);
		final_report();
	end
endmodule : test_daisy_chain_command_timing
`default_nettype wire
